// ---- logic/darr_pkg.sv ----
/*
 * darr_pkg: constants, register offsets, latency figures and types for the
 * dual converter output latency router.
 * Assumes: a single core clock samples the converter sampling clock.
 */
package darr_pkg;
	localparam int unsigned RAW_W          = 12;
	localparam int unsigned CODE_W         = 10;
	localparam int unsigned FS_W           = 15;
	localparam int unsigned GAIN_SHIFT     = 14;
	localparam int unsigned LAT_PRI        = 34;
	localparam int unsigned LAT_DLY        = 35;
	localparam int unsigned HIST_PRI_RISE  = 2 * LAT_PRI - 1;
	localparam int unsigned HIST_PRI_FALL  = 2 * LAT_PRI;
	localparam int unsigned HIST_DLY_RISE  = 2 * LAT_DLY - 1;
	localparam int unsigned HIST_DLY_FALL  = 2 * LAT_DLY;
	localparam int unsigned HIST_DEPTH     = 2 * LAT_DLY + 2;
	localparam int unsigned CAL_FLUSH_CYC  = 60;
	localparam int unsigned SYNC_W         = 2 * RAW_W + 8;
	localparam logic [3:0]  ADDR_FS_I      = 4'h3;
	localparam logic [3:0]  ADDR_FS_Q      = 4'hB;
	localparam logic [FS_W-1:0] FS_RESET   = 15'h4000;
	localparam logic [FS_W-1:0] FS_PIN_LOW = 15'h3000;
	localparam logic [FS_W-1:0] FS_PIN_HIGH = 15'h4000;
	localparam logic [CODE_W-1:0] CODE_MAX = 10'h3FF;
	localparam logic [CODE_W-1:0] CODE_MIN = 10'h000;
	localparam logic [CODE_W-1:0] CODE_MID = 10'h200;
	localparam logic [1:0]  SEL_FIRST      = 2'h0;
	localparam logic [1:0]  SEL_SECOND     = 2'h1;
	localparam logic [1:0]  SEL_BOTH       = 2'h2;
	localparam logic [6:0]  FLUSH_LAST     = 7'h3B;

	typedef enum logic [1:0] {CAL_IDLE, CAL_BUSY, CAL_FLUSH} darr_cal_t;
endpackage

// ---- logic/darr_quant.sv ----
/*
 * darr_quant: scales one raw input by its full-scale word, offsets it to
 * mid code, clips to the 10-bit code range and flags overrange.
 * Assumes: purely combinational use inside the router, same clock domain.
 */
`timescale 1ns/1ps
module darr_quant
	import darr_pkg::*;
(
	input  wire logic [RAW_W-1:0]  raw_i,
	input  wire logic [FS_W-1:0]   scale_i,
	output logic      [CODE_W-1:0] code_o,
	output logic                   over_o
);
	logic signed [RAW_W+FS_W:0] prod;
	logic signed [RAW_W+FS_W:0] level;

	////////////////////////////////////////////////////////////////////////
	// gain, offset and clip
	always_comb
	begin
		prod  = $signed(raw_i) * $signed({1'b0, scale_i});
		level = (prod >>> GAIN_SHIFT) + $signed({{(RAW_W+FS_W-CODE_W){1'b0}}, CODE_MID});
		if (level > $signed({{(RAW_W+FS_W-CODE_W){1'b0}}, CODE_MAX}))
		begin
			code_o = CODE_MAX;
			over_o = 1'b1;
		end
		else if (level < 0)
		begin
			code_o = CODE_MIN;
			over_o = 1'b1;
		end
		else
		begin
			code_o = level[CODE_W-1:0];
			over_o = 1'b0;
		end
	end
endmodule

// ---- logic/darr_fifo.sv ----
/*
 * darr_fifo: synchronous FIFO with valid/ready on both sides.
 * Assumes: one clock, one asynchronous active-low reset; DEPTH a power of two.
 */
`timescale 1ns/1ps
module darr_fifo #(
	parameter int unsigned WIDTH = 22,
	parameter int unsigned DEPTH = 8
)(
	input  wire logic             core_clk_i,
	input  wire logic             arst_n_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic      [WIDTH-1:0] out_data_o
);
	localparam int unsigned AW = $clog2(DEPTH);

	if (DEPTH < 2 || (1 << AW) != DEPTH)
		$error("depth must be a power of two of at least two");

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wr_ptr;
	logic [AW:0]      rd_ptr;
	logic [AW:0]      next_wr_ptr;
	logic [AW:0]      next_rd_ptr;
	logic             push;
	logic             pop;

	////////////////////////////////////////////////////////////////////////
	// pointers and flags
	always_comb
	begin
		in_ready_o  = !((wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
		out_valid_o = (wr_ptr != rd_ptr);
		out_data_o  = mem[rd_ptr[AW-1:0]];
		push        = in_valid_i && in_ready_o;
		pop         = out_valid_o && out_ready_i;
		next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
		next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
	end

	always_ff @(posedge core_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end
		else
		begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
		end
	end

	always_ff @(posedge core_clk_i)
	begin
		if (push)
			mem[wr_ptr[AW-1:0]] <= in_data_i;
	end
endmodule

// ---- logic/darr_router.sv ----
/*
 * darr_router: top of the dual converter output latency router. Samples the
 * converter clock, keeps a half-cycle sample history, drives four output
 * buses at fixed latency, clips and flags overrange, blanks during
 * calibration and mirrors primary words into a capture FIFO.
 * Assumes: sampling clock and all pins asynchronous to core_clk_i and much
 * slower than it; register port synchronous to core_clk_i.
 */
`timescale 1ns/1ps
module darr_router
	import darr_pkg::*;
#(
	parameter int unsigned FIFO_DEPTH = 8
)(
	input  wire logic              core_clk_i,
	input  wire logic              arst_n_i,
	input  wire logic              sample_clk_i,
	input  wire logic [RAW_W-1:0]  raw_first_i,
	input  wire logic [RAW_W-1:0]  raw_second_i,
	input  wire logic              interleave_mode_i,
	input  wire logic              demux_mode_i,
	input  wire logic              extended_control_mode_i,
	input  wire logic [1:0]        input_select_i,
	input  wire logic              full_scale_range_select_i,
	input  wire logic              calibration_running_i,
	input  wire logic              reg_wr_i,
	input  wire logic [3:0]        reg_addr_i,
	input  wire logic [15:0]       reg_wdata_i,
	output logic      [15:0]       reg_rdata_o,
	output logic      [CODE_W-1:0] primary_i_bus_o,
	output logic      [CODE_W-1:0] primary_q_bus_o,
	output logic      [CODE_W-1:0] delayed_i_bus_o,
	output logic      [CODE_W-1:0] delayed_q_bus_o,
	output logic                   delayed_bus_oe_o,
	output logic                   first_channel_overrange_flag_o,
	output logic                   second_channel_overrange_flag_o,
	output logic                   stream_valid_o,
	input  wire logic              stream_ready_i,
	output logic      [2*CODE_W+1:0] stream_data_o,
	output logic                   stream_overflow_o
);
	localparam int unsigned ENT_W = 2 * CODE_W + 2;

	if (FIFO_DEPTH < 2)
		$error("fifo depth below two");

	////////////////////////////////////////////////////////////////////////
	// helpers
	function automatic logic [CODE_W:0] pick(input logic [ENT_W-1:0] ent, input logic use_q);
		pick = use_q ? ent[ENT_W-1:CODE_W+1] : ent[CODE_W:0];
	endfunction

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	logic [SYNC_W-1:0] sync1;
	logic [SYNC_W-1:0] sync2;
	logic              clk_prev;
	logic [SYNC_W-1:0] next_sync1;
	logic [SYNC_W-1:0] next_sync2;
	logic              next_clk_prev;

	logic              s_clk;
	logic [RAW_W-1:0]  s_raw_i;
	logic [RAW_W-1:0]  s_raw_q;
	logic              s_ilv;
	logic              s_demux;
	logic              s_ecm;
	logic [1:0]        s_sel;
	logic              s_fsr;
	logic              s_cal;
	logic              rise;
	logic              fall;

	always_comb
	begin
		next_sync1 = {sample_clk_i, raw_first_i, raw_second_i, interleave_mode_i,
			demux_mode_i, extended_control_mode_i, input_select_i,
			full_scale_range_select_i, calibration_running_i};
		next_sync2    = sync1;
		next_clk_prev = sync2[SYNC_W-1];
		{s_clk, s_raw_i, s_raw_q, s_ilv, s_demux, s_ecm, s_sel, s_fsr, s_cal} = sync2;
		rise = s_clk && !clk_prev;
		fall = !s_clk && clk_prev;
	end

	always_ff @(posedge core_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			sync1    <= '0;
			sync2    <= '0;
			clk_prev <= 1'b0;
		end
		else
		begin
			sync1    <= next_sync1;
			sync2    <= next_sync2;
			clk_prev <= next_clk_prev;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// full-scale registers
	logic [FS_W-1:0] fs_i;
	logic [FS_W-1:0] fs_q;
	logic [15:0]     rdata;
	logic [FS_W-1:0] next_fs_i;
	logic [FS_W-1:0] next_fs_q;
	logic [15:0]     next_rdata;
	logic [FS_W-1:0] scale_i;
	logic [FS_W-1:0] scale_q;

	always_comb
	begin
		next_fs_i = fs_i;
		next_fs_q = fs_q;
		if (reg_wr_i && reg_addr_i == ADDR_FS_I)
			next_fs_i = reg_wdata_i[FS_W-1:0];
		if (reg_wr_i && reg_addr_i == ADDR_FS_Q)
			next_fs_q = reg_wdata_i[FS_W-1:0];
		unique case (reg_addr_i)
			ADDR_FS_I: next_rdata = {1'b0, fs_i};
			ADDR_FS_Q: next_rdata = {1'b0, fs_q};
			default:   next_rdata = 16'h0000;
		endcase
		if (s_ecm)
		begin
			scale_i = fs_i;
			scale_q = fs_q;
		end
		else
		begin
			scale_i = s_fsr ? FS_PIN_HIGH : FS_PIN_LOW;
			scale_q = scale_i;
		end
	end

	always_ff @(posedge core_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			fs_i  <= FS_RESET;
			fs_q  <= FS_RESET;
			rdata <= 16'h0000;
		end
		else
		begin
			fs_i  <= next_fs_i;
			fs_q  <= next_fs_q;
			rdata <= next_rdata;
		end
	end

	assign reg_rdata_o = rdata;

	////////////////////////////////////////////////////////////////////////
	// quantisers
	logic [CODE_W-1:0] code_i;
	logic [CODE_W-1:0] code_q;
	logic              over_i;
	logic              over_q;

	darr_quant u_quant_i (
		.raw_i   (s_raw_i),
		.scale_i (scale_i),
		.code_o  (code_i),
		.over_o  (over_i)
	);

	darr_quant u_quant_q (
		.raw_i   (s_raw_q),
		.scale_i (scale_q),
		.code_o  (code_q),
		.over_o  (over_q)
	);

	////////////////////////////////////////////////////////////////////////
	// half-cycle sample history, free running
	logic [ENT_W-1:0] hist      [HIST_DEPTH];
	logic [ENT_W-1:0] next_hist [HIST_DEPTH];

	always_comb
	begin
		for (int k = 0; k < HIST_DEPTH; k++)
			next_hist[k] = hist[k];
		if (rise || fall)
		begin
			next_hist[0] = {over_q, code_q, over_i, code_i};
			for (int k = 1; k < HIST_DEPTH; k++)
				next_hist[k] = hist[k-1];
		end
	end

	always_ff @(posedge core_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			for (int k = 0; k < HIST_DEPTH; k++)
				hist[k] <= '0;
		end
		else
		begin
			for (int k = 0; k < HIST_DEPTH; k++)
				hist[k] <= next_hist[k];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// calibration blanking
	darr_cal_t cal_state;
	darr_cal_t next_cal_state;
	logic [6:0] flush_cnt;
	logic [6:0] next_flush_cnt;
	logic       hold;

	always_comb
	begin
		next_cal_state = cal_state;
		next_flush_cnt = flush_cnt;
		unique case (cal_state)
			CAL_IDLE:
				if (s_cal)
					next_cal_state = CAL_BUSY;
			CAL_BUSY:
				if (!s_cal)
				begin
					next_cal_state = CAL_FLUSH;
					next_flush_cnt = '0;
				end
			CAL_FLUSH:
				if (s_cal)
					next_cal_state = CAL_BUSY;
				else if (rise && flush_cnt == FLUSH_LAST)
					next_cal_state = CAL_IDLE;
				else if (rise)
					next_flush_cnt = flush_cnt + 7'h01;
		endcase
		hold = (cal_state != CAL_IDLE) || s_cal;
	end

	always_ff @(posedge core_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			cal_state <= CAL_IDLE;
			flush_cnt <= '0;
		end
		else
		begin
			cal_state <= next_cal_state;
			flush_cnt <= next_flush_cnt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// output buses
	logic              src_q;
	logic              phase;
	logic              update;
	logic [CODE_W:0]   w_pi;
	logic [CODE_W:0]   w_pq;
	logic [CODE_W:0]   w_di;
	logic [CODE_W:0]   w_dq;
	logic              next_phase;
	logic [CODE_W-1:0] next_pi;
	logic [CODE_W-1:0] next_pq;
	logic [CODE_W-1:0] next_di;
	logic [CODE_W-1:0] next_dq;
	logic              next_oe;
	logic              next_of1;
	logic              next_of2;

	always_comb
	begin
		src_q  = s_ilv && s_ecm && (s_sel == SEL_SECOND);
		w_pi   = pick(hist[HIST_PRI_RISE], src_q);
		w_di   = pick(hist[HIST_DLY_RISE], src_q);
		w_pq   = s_ilv ? pick(hist[HIST_PRI_FALL], src_q)
			: pick(hist[HIST_PRI_RISE], 1'b1);
		w_dq   = s_ilv ? pick(hist[HIST_DLY_FALL], src_q)
			: pick(hist[HIST_DLY_RISE], 1'b1);
		next_phase = (rise && s_demux) ? !phase : phase;
		update = rise && (!s_demux || !phase);
		next_oe  = s_demux;
		next_pi  = primary_i_bus_o;
		next_pq  = primary_q_bus_o;
		next_di  = delayed_i_bus_o;
		next_dq  = delayed_q_bus_o;
		next_of1 = first_channel_overrange_flag_o;
		next_of2 = second_channel_overrange_flag_o;
		if (hold)
		begin
			next_pi  = '0;
			next_pq  = '0;
			next_di  = '0;
			next_dq  = '0;
			next_of1 = 1'b0;
			next_of2 = 1'b0;
		end
		else if (update)
		begin
			next_pi  = w_pi[CODE_W-1:0];
			next_pq  = w_pq[CODE_W-1:0];
			next_di  = s_demux ? w_di[CODE_W-1:0] : '0;
			next_dq  = s_demux ? w_dq[CODE_W-1:0] : '0;
			next_of1 = w_pi[CODE_W] || (s_demux && w_di[CODE_W]);
			next_of2 = w_pq[CODE_W] || (s_demux && w_dq[CODE_W]);
		end
	end

	always_ff @(posedge core_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			phase                           <= 1'b0;
			primary_i_bus_o                 <= '0;
			primary_q_bus_o                 <= '0;
			delayed_i_bus_o                 <= '0;
			delayed_q_bus_o                 <= '0;
			delayed_bus_oe_o                <= 1'b0;
			first_channel_overrange_flag_o  <= 1'b0;
			second_channel_overrange_flag_o <= 1'b0;
		end
		else
		begin
			phase                           <= next_phase;
			primary_i_bus_o                 <= next_pi;
			primary_q_bus_o                 <= next_pq;
			delayed_i_bus_o                 <= next_di;
			delayed_q_bus_o                 <= next_dq;
			delayed_bus_oe_o                <= next_oe;
			first_channel_overrange_flag_o  <= next_of1;
			second_channel_overrange_flag_o <= next_of2;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// capture stream
	logic             fifo_push;
	logic             fifo_ready;
	logic [ENT_W-1:0] fifo_in;
	logic             next_overflow;

	always_comb
	begin
		fifo_push     = update && !hold;
		fifo_in       = {w_pq[CODE_W], w_pi[CODE_W], w_pq[CODE_W-1:0], w_pi[CODE_W-1:0]};
		next_overflow = stream_overflow_o || (fifo_push && !fifo_ready);
	end

	always_ff @(posedge core_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			stream_overflow_o <= 1'b0;
		else
			stream_overflow_o <= next_overflow;
	end

	darr_fifo #(
		.WIDTH (ENT_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.core_clk_i  (core_clk_i),
		.arst_n_i    (arst_n_i),
		.in_valid_i  (fifo_push),
		.in_ready_o  (fifo_ready),
		.in_data_i   (fifo_in),
		.out_valid_o (stream_valid_o),
		.out_ready_i (stream_ready_i),
		.out_data_o  (stream_data_o)
	);

	////////////////////////////////////////////////////////////////////////
	// checks
	cal_blank_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		s_cal |=> primary_i_bus_o == '0 && primary_q_bus_o == '0 && !first_channel_overrange_flag_o)
		else $error("outputs not low during calibration");

	flush_hold_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		$fell(s_cal) |=> cal_state == CAL_FLUSH && flush_cnt == '0)
		else $error("flush count not restarted after calibration");

	flush_len_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		cal_state == CAL_FLUSH && flush_cnt < FLUSH_LAST |=> cal_state != CAL_IDLE)
		else $error("blanking ended early");

	delayed_hiz_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		!s_demux ##1 !s_demux |-> !delayed_bus_oe_o)
		else $error("delayed buses driven in non-demux mode");

	clip_range_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		over_i |-> code_i == CODE_MAX || code_i == CODE_MIN)
		else $error("overrange result not clipped");

	first_only_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		!s_ecm |-> !src_q)
		else $error("second input used without extended control");

	shared_range_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		!s_ecm |-> scale_i == scale_q)
		else $error("channels differ in range without extended control");

	edge_capture_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		(rise || fall) |=> hist[0] == {$past(over_q), $past(code_q), $past(over_i), $past(code_i)}
			&& hist[1] == $past(hist[0]))
		else $error("sample history not advanced on sampling edge");

	demux_rate_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		rise && s_demux && phase && !hold |=> $stable(primary_i_bus_o) && $stable(delayed_i_bus_o))
		else $error("demux update on wrong phase");
endmodule

// ---- dv/darr_capture.sv ----
/*
 * darr_capture: downstream capture model taking words from the stream port.
 * Assumes: core clock domain; the bench asks for stalls through stall_i.
 */
`timescale 1ns/1ps
module darr_capture (
	input  wire logic        core_clk_i,
	input  wire logic        arst_n_i,
	input  wire logic        stall_i,
	input  wire logic        stream_valid_i,
	input  wire logic [21:0] stream_data_i,
	output logic             stream_ready_o,
	output logic [7:0]       pops_o,
	output logic [21:0]      last_word_o
);
	// primary I word in low half, primary Q word (fall word in interleave mode) in high half of each update
	always_ff @(posedge core_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			stream_ready_o <= 1'b0;
			pops_o         <= 8'h00;
			last_word_o    <= 22'h000000;
		end
		else
		begin
			stream_ready_o <= !stall_i;
			if (stream_valid_i && stream_ready_o)
			begin
				pops_o      <= pops_o + 8'h01;
				last_word_o <= stream_data_i;
			end
		end
	end
endmodule

// ---- dv/tb_darr_router.sv ----
/*
 * tb_darr_router: directed bench for the latency router and capture path.
 * Assumes: darr_pkg and design files compiled first, darr_capture as far side.
 */
`timescale 1ns/1ps
module tb_darr_router
	import darr_pkg::*;
;
	logic              clk = 1'b0;
	logic              rst_n = 1'b0;
	logic              sclk = 1'b0;
	logic              run = 1'b0;
	logic [RAW_W-1:0]  rf = 12'h000;
	logic [RAW_W-1:0]  rs = 12'h000;
	logic              ilv = 1'b0;
	logic              dmx = 1'b1;
	logic              extended_control_mode = 1'b0;
	logic [1:0]        sel = 2'h0;
	logic              full_scale_range_select = 1'b1;
	logic              cal = 1'b0;
	logic              wr = 1'b0;
	logic [3:0]        addr = 4'h0;
	logic [15:0]       wd = 16'h0000;
	logic              stall = 1'b0;
	logic [15:0]       rd;
	logic [CODE_W-1:0] pi, pq, di, dq;
	logic              oe, ofi, ofq, sv, rdy, sov;
	logic [21:0]       sd, last;
	logic [7:0]        pops;
	logic [FS_W-1:0]   fs_i = FS_RESET;
	logic [FS_W-1:0]   fs_q = FS_RESET;
	logic [RAW_W-1:0]  h1 [0:127];
	logic [RAW_W-1:0]  h2 [0:127];
	int                k = 0;
	int                cyc = 0;
	int                miscompares = 0;
	int                checks_done = 0;

	darr_router #(.FIFO_DEPTH(8)) darr_router_i (
		.core_clk_i(clk), .arst_n_i(rst_n), .sample_clk_i(sclk),
		.raw_first_i(rf), .raw_second_i(rs), .interleave_mode_i(ilv),
		.demux_mode_i(dmx), .extended_control_mode_i(extended_control_mode), .input_select_i(sel),
		.full_scale_range_select_i(full_scale_range_select), .calibration_running_i(cal),
		.reg_wr_i(wr), .reg_addr_i(addr), .reg_wdata_i(wd), .reg_rdata_o(rd),
		.primary_i_bus_o(pi), .primary_q_bus_o(pq), .delayed_i_bus_o(di),
		.delayed_q_bus_o(dq), .delayed_bus_oe_o(oe),
		.first_channel_overrange_flag_o(ofi), .second_channel_overrange_flag_o(ofq),
		.stream_valid_o(sv), .stream_ready_i(rdy), .stream_data_o(sd),
		.stream_overflow_o(sov));

	darr_capture darr_capture_i (
		.core_clk_i(clk), .arst_n_i(rst_n), .stall_i(stall), .stream_valid_i(sv),
		.stream_data_i(sd), .stream_ready_o(rdy), .pops_o(pops), .last_word_o(last));

	////////////////////////////////////////////////////////////////////////////
	always #2.5 clk = ~clk;

	// sampling clock, raw values move mid half period
	always
	begin
		#12;
		rf = 12'(((k * 29) % 900) - 450);
		rs = 12'(300 - ((k * 13) % 700));
		#12;
		if (run || sclk)
		begin
			h1[k % 128] = rf;
			h2[k % 128] = rs;
			sclk = ~sclk;
			k++;
		end
	end

	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 12000)
		begin
			miscompares++;
			stop_test();
		end
	end

	////////////////////////////////////////////////////////////////////////////
	task automatic stop_test();
		if (miscompares == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic chk(input string n, input logic [47:0] e, input logic [47:0] g);
		checks_done++;
		if (g !== e)
		begin
			miscompares++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask

	function automatic logic [10:0] cv(input logic [11:0] r, input logic [14:0] s);
		int v;
		v = (($signed(r) * int'(s)) >>> 14) + 512;
		if (v > 1023)
			return {1'b1, 10'h3FF};
		if (v < 0)
			return {1'b1, 10'h000};
		return {1'b0, v[9:0]};
	endfunction

	task automatic check_buses();
		int               e;
		logic             sec;
		logic [RAW_W-1:0] a, b, c, d;
		logic [FS_W-1:0]  si, sq;
		logic [10:0]      xa, xb, xc, xd;
		e = k - 2;
		if (dmx && ((e / 2) % 2) != 0)
			e = e - 2;
		sec = ilv && extended_control_mode && sel == SEL_SECOND;
		si = extended_control_mode ? fs_i : (full_scale_range_select ? FS_PIN_HIGH : FS_PIN_LOW);
		sq = extended_control_mode ? fs_q : si;
		a = sec ? h2[(e - 68) % 128] : h1[(e - 68) % 128];
		b = ilv ? (sec ? h2[(e - 69) % 128] : h1[(e - 69) % 128]) : h2[(e - 68) % 128];
		c = sec ? h2[(e - 70) % 128] : h1[(e - 70) % 128];
		d = ilv ? (sec ? h2[(e - 71) % 128] : h1[(e - 71) % 128]) : h2[(e - 70) % 128];
		xa = cv(a, si);
		xb = cv(b, sq);
		xc = dmx ? cv(c, si) : 11'h000;
		xd = dmx ? cv(d, sq) : 11'h000;
		chk("buses", 48'({dmx, xa[10] | xc[10], xb[10] | xd[10], xa[9:0], xb[9:0],
			xc[9:0], xd[9:0]}), 48'({oe, ofi, ofq, pi, pq, di, dq}));
	endtask

	task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
		@(negedge clk);
		addr = a;
		wd = d;
		wr = 1'b1;
		@(negedge clk);
		wr = 1'b0;
	endtask

	task automatic reg_read(input logic [3:0] a, output logic [15:0] v);
		@(negedge clk);
		addr = a;
		@(negedge clk);
		v = rd;
	endtask

	task automatic run_mode(input logic i, input logic d, input logic m,
		input logic [1:0] s, input logic f);
		@(negedge clk);
		ilv = i;
		dmx = d;
		extended_control_mode = m;
		sel = s;
		full_scale_range_select = f;
		repeat (36) @(posedge sclk);
		repeat (4)
		begin
			@(posedge sclk);
			#34;
			check_buses();
		end
	endtask

	////////////////////////////////////////////////////////////////////////////
	task automatic t_modes();
		run_mode(1'b0, 1'b1, 1'b0, SEL_FIRST, 1'b1);
		run_mode(1'b1, 1'b1, 1'b0, SEL_FIRST, 1'b1);
		run_mode(1'b1, 1'b1, 1'b0, SEL_BOTH, 1'b1);
		run_mode(1'b1, 1'b1, 1'b0, SEL_SECOND, 1'b1);
		run_mode(1'b1, 1'b1, 1'b1, SEL_SECOND, 1'b1);
		run_mode(1'b0, 1'b0, 1'b0, SEL_FIRST, 1'b1);
		run_mode(1'b1, 1'b0, 1'b0, SEL_FIRST, 1'b1);
	endtask

	task automatic t_range();
		logic [15:0] v;
		run_mode(1'b0, 1'b0, 1'b0, SEL_FIRST, 1'b0);
		reg_write(ADDR_FS_I, 16'h2000);
		reg_write(ADDR_FS_Q, 16'hFFFF);
		reg_write(4'h5, 16'h1111);
		fs_i = 15'h2000;
		fs_q = 15'h7FFF;
		reg_read(ADDR_FS_I, v);
		chk("fs_i", 48'(16'h2000), 48'(v));
		reg_read(ADDR_FS_Q, v);
		chk("fs_q", 48'(16'h7FFF), 48'(v));
		reg_read(4'h5, v);
		chk("unmapped", 48'h0, 48'(v));
		run_mode(1'b0, 1'b0, 1'b0, SEL_FIRST, 1'b1);
		run_mode(1'b0, 1'b0, 1'b1, SEL_FIRST, 1'b0);
	endtask

	task automatic t_cal();
		@(negedge clk);
		cal = 1'b1;
		for (int n = -3; n <= 63; n++)
		begin
			@(posedge sclk);
			#34;
			if (n == 0)
			begin
				@(negedge clk);
				cal = 1'b0;
			end
			if (n <= 59)
				chk("cal_hold", 48'h0, 48'({oe, ofi, ofq, pi, pq, di, dq}));
			else if (n >= 61)
				check_buses();
		end
	endtask

	task automatic t_fifo();
		logic [7:0] p0;
		chk("overflow", 48'h0, 48'(sov));
		@(negedge clk);
		stall = 1'b1;
		repeat (12) @(posedge sclk);
		#34;
		chk("full", 48'h3, 48'({sov, sv}));
		run = 1'b0;
		repeat (20) @(negedge clk);
		p0 = pops;
		stall = 1'b0;
		repeat (20) @(negedge clk);
		chk("drained", 48'(10'h208), 48'({sov, sv, 8'(pops - p0)}));
		run = 1'b1;
		@(posedge sclk);
		#34;
		run = 1'b0;
		repeat (4) @(negedge clk);
		chk("last_word", 48'({ofq, ofi, pq, pi}), 48'(last));
	endtask

	task automatic t_reset();
		logic [15:0] v;
		run = 1'b1;
		@(negedge clk);
		rst_n = 1'b0;
		@(negedge clk);
		chk("reset_out", 48'h0, 48'({oe, ofi, ofq, pi, pq, di, dq, sv, sov}));
		rst_n = 1'b1;
		reg_read(ADDR_FS_Q, v);
		chk("fs_reset", 48'({1'b0, FS_RESET}), 48'(v));
	endtask

	initial
	begin
		repeat (2) @(posedge clk);
		@(negedge clk);
		rst_n = 1'b1;
		repeat (3) @(negedge clk);
		run = 1'b1;
		t_modes();
		t_range();
		t_cal();
		t_fifo();
		t_reset();
		stop_test();
	end
endmodule
